// File: pwm_timebase.v
// Standard PWM unit: period timer, double-buffered duty, Avalon-MM registers
`include "pwm_timebase_defs.vh"
`default_nettype none
module pwm_timebase (
   input wire mclk_in,
   input wire rstn_in,
   input wire ce_in,
   input wire [4:0] avs_address_in,
   input wire avs_read_in,
   input wire avs_write_in,
   input wire [31:0] avs_writedata_in,
   input wire [3:0] avs_byteenable_in,
   output reg [31:0] avs_readdata_out,
   output reg avs_waitrequest_out,
   output reg pwm_out,
   output reg pwm_oe_out,
   output wire irq_out
);
   //------------------------------------------------------------
   // Registers seen by software
   //------------------------------------------------------------
   // Control: run, prescale, alignment, driver, enable
   reg [`CTL_WIDTH-1:0] control_r;
   // Period match value
   reg [7:0] period_match_register_r;
   // Duty pair as written
   reg [7:0] duty_high_register_r;
   reg [7:0] duty_low_register_r;
   // Interrupt mask
   reg [`STS_WIDTH-1:0] mask_r;

   //------------------------------------------------------------
   // Time base state
   //------------------------------------------------------------
   // Shared 8-bit period counter
   reg [7:0] period_counter_r;
   // Clock phase within one counter increment
   reg [1:0] phase_r;
   // Active 10-bit duty shadow
   reg [9:0] duty_shadow_r;
   // One-cycle pulse at each period match
   reg period_event_r;

   //------------------------------------------------------------
   // Decoded control fields
   //------------------------------------------------------------
   wire run_bit = control_r[`CTL_RUN_BIT];
   wire [1:0] prescale_sel = control_r[`CTL_PRESCALE_MSB:`CTL_PRESCALE_LSB];
   wire align_left = control_r[`CTL_ALIGN_BIT];
   wire drive_bit = control_r[`CTL_DRIVE_BIT];
   wire pwm_enable = control_r[`CTL_PWM_EN_BIT];

   // Prescaled quarter-step pulse
   wire quarter_tick;
   // Sticky flags from the interrupt block
   wire [`STS_WIDTH-1:0] status_flags;

   //------------------------------------------------------------
   // Bus access decode
   //------------------------------------------------------------
   // Request present on the bus
   wire bus_req = avs_read_in | avs_write_in;
   // Edge at which the access completes
   wire bus_done = bus_req & ~avs_waitrequest_out;
   wire wr_done = avs_write_in & bus_done;
   // Status read clears the sticky flags at the edge that latches the read
   // data, so a flag set while the read completes is not lost
   wire status_read = avs_read_in & avs_waitrequest_out & (avs_address_in == `OFS_STATUS);

   // Combined duty value under the chosen alignment
   function [9:0] duty_value;
      input left;
      input [7:0] hi;
      input [7:0] lo;
      begin
         if (left)
            duty_value = {hi, lo[7:6]};
         else
            duty_value = {hi[1:0], lo};
      end
   endfunction

   // Write with lowest byte lane enabled
   function lane0_write;
      input wr;
      input [4:0] addr;
      input [4:0] ofs;
      input [3:0] be;
      begin
         lane0_write = wr & (addr == ofs) & be[0];
      end
   endfunction

   //------------------------------------------------------------
   // Timing derivation
   //------------------------------------------------------------
   // Counter steps once per PHASES_PER_STEP prescaled clocks
   wire step_end = quarter_tick & (phase_r == `PHASE_LAST);
   // Counter has reached the match value at the end of a step
   wire period_match = step_end & (period_counter_r == period_match_register_r);
   // Shadow value that the new period will use
   wire [9:0] duty_next = duty_value(align_left, duty_high_register_r, duty_low_register_r);
   // Extended 10-bit time base
   wire [9:0] time_base = {period_counter_r, phase_r};
   // Time base one quarter step ahead, so the output falls as the base reaches duty
   wire [10:0] time_base_sum = {1'b0, time_base} + 11'h001;

   //------------------------------------------------------------
   // Prescaler
   //------------------------------------------------------------
   pwm_prescaler u_prescaler (
      .mclk_in(mclk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .run_in(run_bit),
      .ratio_sel_in(prescale_sel),
      .tick_out(quarter_tick)
   );

   //------------------------------------------------------------
   // Period counter and phase
   //------------------------------------------------------------
   // Counter lives in the shared timer; it wraps at the match, or on overflow past 8'hFF when the match lies below it,
   // no postscaler stands between match and period
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         period_counter_r <= 8'h00;
         phase_r <= 2'h0;
      end else if (ce_in) begin
         if (quarter_tick) begin
            phase_r <= phase_r + 2'h1;
            if (period_match)
               period_counter_r <= 8'h00;
            else if (step_end)
               period_counter_r <= period_counter_r + 8'h01;
         end
      end
   end

   //------------------------------------------------------------
   // Duty shadow
   //------------------------------------------------------------
   // Loaded only at a match, so duty writes never glitch a period
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         duty_shadow_r <= 10'h000;
      end else if (ce_in) begin
         if (period_match)
            duty_shadow_r <= duty_next;
      end
   end

   //------------------------------------------------------------
   // Period event pulse
   //------------------------------------------------------------
   // Drives the sticky period timer flag
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         period_event_r <= 1'b0;
      end else if (ce_in) begin
         period_event_r <= period_match;
      end
   end

   //------------------------------------------------------------
   // Modulated output
   //------------------------------------------------------------
   // Rises at period start unless duty is zero; falls on the step at
   // which the time base becomes the shadow duty, giving duty x ratio
   // clocks high. A duty above the period never matches, so the
   // output stays high the whole period.
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pwm_out <= 1'b0;
      end else if (ce_in) begin
         if (!pwm_enable) begin
            // Disabled unit parks low
            pwm_out <= 1'b0;
         end else if (period_match) begin
            pwm_out <= (duty_next != 10'h000);
         end else if (quarter_tick && (time_base_sum[9:0] == duty_shadow_r)) begin
            pwm_out <= 1'b0;
         end
      end
   end

   //------------------------------------------------------------
   // Pin driver enable
   //------------------------------------------------------------
   // Software turns the driver on after the first flag
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pwm_oe_out <= 1'b0;
      end else if (ce_in) begin
         pwm_oe_out <= drive_bit;
      end
   end

   //------------------------------------------------------------
   // Register writes
   //------------------------------------------------------------
   // Duty pair accepts writes at any time; the shadow isolates them
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         control_r <= `RST_CONTROL;
         period_match_register_r <= `RST_PERIOD;
         duty_high_register_r <= `RST_DUTY;
         duty_low_register_r <= `RST_DUTY;
         mask_r <= `RST_MASK;
      end else if (ce_in) begin
         if (lane0_write(wr_done, avs_address_in, `OFS_CONTROL, avs_byteenable_in))
            control_r <= avs_writedata_in[`CTL_WIDTH-1:0];
         if (lane0_write(wr_done, avs_address_in, `OFS_PERIOD, avs_byteenable_in))
            period_match_register_r <= avs_writedata_in[7:0];
         if (lane0_write(wr_done, avs_address_in, `OFS_DUTY_HIGH, avs_byteenable_in))
            duty_high_register_r <= avs_writedata_in[7:0];
         if (lane0_write(wr_done, avs_address_in, `OFS_DUTY_LOW, avs_byteenable_in))
            duty_low_register_r <= avs_writedata_in[7:0];
         if (lane0_write(wr_done, avs_address_in, `OFS_MASK, avs_byteenable_in))
            mask_r <= avs_writedata_in[`STS_WIDTH-1:0];
      end
   end

   //------------------------------------------------------------
   // Read multiplexer
   //------------------------------------------------------------
   // Unmapped offsets read as zero
   reg [31:0] read_mux;
   always @* begin
      read_mux = 32'h0000_0000;
      case (avs_address_in)
         `OFS_CONTROL: read_mux[`CTL_WIDTH-1:0] = control_r;
         `OFS_PERIOD: read_mux[7:0] = period_match_register_r;
         `OFS_DUTY_HIGH: read_mux[7:0] = duty_high_register_r;
         `OFS_DUTY_LOW: read_mux[7:0] = duty_low_register_r;
         `OFS_STATUS: read_mux[`STS_WIDTH:0] = {pwm_out, status_flags};
         `OFS_MASK: read_mux[`STS_WIDTH-1:0] = mask_r;
         `OFS_COUNTER: read_mux[9:0] = time_base;
         default: read_mux = 32'h0000_0000;
      endcase
   end

   //------------------------------------------------------------
   // Bus handshake
   //------------------------------------------------------------
   // Every access takes one wait state: waitrequest drops one clock
   // after a request appears, data latched then, and rises again
   // at the completing edge
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         avs_waitrequest_out <= 1'b1;
         avs_readdata_out <= 32'h0000_0000;
      end else if (ce_in) begin
         if (bus_req & avs_waitrequest_out) begin
            avs_waitrequest_out <= 1'b0;
            avs_readdata_out <= avs_read_in ? read_mux : 32'h0000_0000;
         end else begin
            avs_waitrequest_out <= 1'b1;
         end
      end
   end

   //------------------------------------------------------------
   // Sticky flags and interrupt
   //------------------------------------------------------------
   pwm_irq_status #(
      .WIDTH(`STS_WIDTH)
   ) u_irq (
      .mclk_in(mclk_in),
      .rstn_in(rstn_in),
      .ce_in(ce_in),
      .event_in(period_event_r),
      .read_clear_in(status_read),
      .mask_in(mask_r),
      .status_out(status_flags),
      .irq_out(irq_out)
   );
endmodule
`default_nettype wire

// File: pwm_timebase_defs.vh
// Register map, field positions, reset values and timing counts of the PWM time base
`ifndef PWM_TIMEBASE_DEFS_VH
`define PWM_TIMEBASE_DEFS_VH

//------------------------------------------------------------
// Register byte offsets
//------------------------------------------------------------
`define OFS_CONTROL 5'h00
`define OFS_PERIOD 5'h04
`define OFS_DUTY_HIGH 5'h08
`define OFS_DUTY_LOW 5'h0C
`define OFS_STATUS 5'h10
`define OFS_MASK 5'h14
`define OFS_COUNTER 5'h18

//------------------------------------------------------------
// Control register fields
//------------------------------------------------------------
`define CTL_RUN_BIT 0
`define CTL_PRESCALE_LSB 1
`define CTL_PRESCALE_MSB 2
`define CTL_ALIGN_BIT 3
`define CTL_DRIVE_BIT 4
`define CTL_PWM_EN_BIT 5
`define CTL_WIDTH 6

//------------------------------------------------------------
// Status and mask fields
//------------------------------------------------------------
`define STS_PERIOD_FLAG_BIT 0
`define STS_WIDTH 1

//------------------------------------------------------------
// Reset values
//------------------------------------------------------------
`define RST_CONTROL 6'h00
`define RST_PERIOD 8'hFF
`define RST_DUTY 8'h00
`define RST_MASK 1'h0

//------------------------------------------------------------
// Timing: prescaled clocks per counter increment
//------------------------------------------------------------
`define PHASES_PER_STEP 4
`define PHASE_LAST 2'h3

`endif

// File: pwm_prescaler.v
// Prescaler that emits one enable pulse every 1, 4, 16 or 64 clocks
`default_nettype none
module pwm_prescaler (
   input wire mclk_in,
   input wire rstn_in,
   input wire ce_in,
   input wire run_in,
   input wire [1:0] ratio_sel_in,
   output reg tick_out
);
   // Free count of clocks within one prescaled step
   reg [5:0] count_r;
   // Last count value for the selected ratio
   function [5:0] ratio_last;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: ratio_last = 6'h00;
            2'h1: ratio_last = 6'h03;
            2'h2: ratio_last = 6'h0F;
            default: ratio_last = 6'h3F;
         endcase
      end
   endfunction
   //------------------------------------------------------------
   // Counting
   //------------------------------------------------------------
   // Stopped timer holds the count at zero so a start is clean
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         count_r <= 6'h00;
         tick_out <= 1'b0;
      end else if (ce_in) begin
         if (!run_in) begin
            count_r <= 6'h00;
            tick_out <= 1'b0;
         end else if (count_r >= ratio_last(ratio_sel_in)) begin
            count_r <= 6'h00;
            tick_out <= 1'b1;
         end else begin
            count_r <= count_r + 6'h01;
            tick_out <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: pwm_irq_status.v
// Sticky event flags cleared by a read, a mask, and one level interrupt
`default_nettype none
module pwm_irq_status #(
   parameter WIDTH = 1
) (
   input wire mclk_in,
   input wire rstn_in,
   input wire ce_in,
   input wire [WIDTH-1:0] event_in,
   input wire read_clear_in,
   input wire [WIDTH-1:0] mask_in,
   output reg [WIDTH-1:0] status_out,
   output reg irq_out
);
   // Next value of the sticky flags
   wire [WIDTH-1:0] status_nxt;
   // A new event in the clearing cycle survives the clear
   assign status_nxt = (read_clear_in ? {WIDTH{1'b0}} : status_out) | event_in;
   //------------------------------------------------------------
   // Flags and interrupt
   //------------------------------------------------------------
   // Interrupt registered from the next flag value, so it changes in the same clock as the flags
   always @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         status_out <= {WIDTH{1'b0}};
         irq_out <= 1'b0;
      end else if (ce_in) begin
         status_out <= status_nxt;
         irq_out <= |(status_nxt & mask_in);
      end
   end
endmodule
`default_nettype wire

// File: pwm_timebase_chk.sv
// Checker for bus handshake, pin and interrupt relations of the PWM unit
`include "pwm_timebase_defs.vh"
`default_nettype none
module pwm_timebase_chk (
   input wire logic mclk_in,
   input wire logic rstn_in,
   input wire logic ce_in,
   input wire logic [4:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic pwm_out,
   input wire logic pwm_oe_out,
   input wire logic irq_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic drive_r; // Last written drive enable
   logic en_r; // Last written modulation enable
   logic mask_r; // Last written interrupt mask
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   // ------
   // Bus completions
   // ------
   sequence wr_done_s;
      avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
   endsequence
   sequence rd_done_s;
      avs_read_in && !avs_waitrequest_out;
   endsequence
   // Mirror of control and mask bits taken from completed writes
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         drive_r <= 1'b0;
         en_r <= 1'b0;
         mask_r <= 1'b0;
      end else if (ce_in && avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]) begin
         if (avs_address_in == `OFS_CONTROL) begin
            drive_r <= avs_writedata_in[`CTL_DRIVE_BIT];
            en_r <= avs_writedata_in[`CTL_PWM_EN_BIT];
         end
         if (avs_address_in == `OFS_MASK) begin
            mask_r <= avs_writedata_in[0];
         end
      end
   end
   // ------
   // Properties
   // ------
   wait_one_a: assert property (ce_in && (avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("request not answered after one wait state");
   wait_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("wait request low longer than one cycle");
   wait_cause_a: assert property ($fell(avs_waitrequest_out) |-> $past(avs_read_in) || $past(avs_write_in))
      else $error("answer without a request");
   unmapped_zero_a: assert property (rd_done_s ##0 (avs_address_in > `OFS_COUNTER) |-> avs_readdata_out == 32'h0)
      else $error("unmapped read not zero");
   upper_zero_a: assert property (rd_done_s |-> avs_readdata_out[31:10] == 22'h0)
      else $error("unused read bits not zero");
   oe_follow_a: assert property (wr_done_s ##0 (avs_address_in == `OFS_CONTROL) |-> ##2 (pwm_oe_out == drive_r))
      else $error("driver enable does not follow control");
   pwm_off_a: assert property ((!en_r) [*3] |-> !pwm_out)
      else $error("output high while disabled");
   rise_gap_a: assert property ($rose(pwm_out) |=> (!$rose(pwm_out)) [*3])
      else $error("period shorter than four clocks");
   irq_mask_a: assert property ((!mask_r) [*3] |-> !irq_out)
      else $error("interrupt while masked");
endmodule
bind pwm_timebase pwm_timebase_chk chk_i (.mclk_in(mclk_in), .rstn_in(rstn_in), .ce_in(ce_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .pwm_out(pwm_out), .pwm_oe_out(pwm_oe_out), .irq_out(irq_out));
`default_nettype wire

// File: pwm_pin_load.sv
// Load model: output pin with a pull-down that measures period and high time
`default_nettype none
module pwm_pin_load (
   input wire logic mclk_in,
   input wire logic drv_in,
   input wire logic oe_in,
   output logic pin_out,
   output logic [15:0] per_out,
   output logic [15:0] high_out,
   output logic [15:0] rise_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pin_d; // Pin level one clock ago
   logic [15:0] cyc; // Clocks since last rise
   logic [15:0] hi; // High clocks since last rise
   // Released pin falls to the pull-down level
   assign pin_out = oe_in ? drv_in : 1'b0;
   initial begin
      pin_d = 1'b0;
      cyc = 16'h0;
      hi = 16'h0;
      per_out = 16'h0;
      high_out = 16'h0;
      rise_out = 16'h0;
   end
   // Close the measurement of one period at each rise
   always @(posedge mclk_in) begin
      pin_d <= pin_out;
      if (pin_out && !pin_d) begin
         per_out <= cyc;
         high_out <= hi;
         rise_out <= rise_out + 16'h1;
         cyc <= 16'h1;
         hi <= 16'h1;
      end else begin
         cyc <= cyc + 16'h1;
         hi <= hi + {15'h0, pin_out};
      end
   end
endmodule
`default_nettype wire

// File: tb_top.sv
// Testbench: register setup, timing rows and hand-written edge cases
`include "pwm_timebase_defs.vh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_in, rstn_in, rd, wr, wait_q, pwm, oe, irq, pin;
   logic [4:0] adr;
   logic [31:0] wdat, rdat, got;
   logic [3:0] be;
   logic [15:0] per, high, rises;
   int err_count, tests_run;
   typedef struct {logic [1:0] ps; logic [7:0] prd, dh, dl; logic al; logic [15:0] eper, ehigh;} row_t;
   // Prescale, period, duty pair, alignment, then expected period and high clocks
   row_t rows [4] = '{'{2'h0, 8'h00, 8'h00, 8'h02, 1'b0, 16'h0004, 16'h0002},
      '{2'h1, 8'h03, 8'h02, 8'h40, 1'b1, 16'h0040, 16'h0024},
      '{2'h2, 8'h01, 8'h00, 8'h05, 1'b0, 16'h0080, 16'h0050},
      '{2'h3, 8'h00, 8'h00, 8'h40, 1'b1, 16'h0100, 16'h0040}};
   logic [4:0] rv_adr [5] = '{`OFS_CONTROL, `OFS_PERIOD, `OFS_DUTY_HIGH, `OFS_DUTY_LOW, `OFS_MASK};
   logic [31:0] rv_exp [5] = '{32'h0, 32'hFF, 32'h0, 32'h0, 32'h0};
   pwm_timebase DUT (.mclk_in(mclk_in), .rstn_in(rstn_in), .ce_in(1'b1), .avs_address_in(adr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(be),
      .avs_readdata_out(rdat), .avs_waitrequest_out(wait_q), .pwm_out(pwm), .pwm_oe_out(oe), .irq_out(irq));
   pwm_pin_load load_i (.mclk_in(mclk_in), .drv_in(pwm), .oe_in(oe), .pin_out(pin), .per_out(per),
      .high_out(high), .rise_out(rises));
   // ------
   // Tasks
   // ------
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One bus cycle, held until wait request is sampled low
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
      int n;
      n = 0;
      @(posedge mclk_in);
      wr <= w;
      rd <= !w;
      adr <= a;
      wdat <= d;
      be <= b;
      do begin
         @(posedge mclk_in);
         n++;
      end while (wait_q !== 1'b0 && n < 20);
      chk("bus answer", {31'h0, wait_q}, 32'h0);
      got = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic do_reset();
      rstn_in <= 1'b0;
      repeat (6) @(posedge mclk_in);
      rstn_in <= 1'b1;
   endtask
   task automatic wait_rise(input int n);
      int k;
      int base;
      k = 0;
      base = rises;
      while (rises < base + n && k < 4000) begin
         @(posedge mclk_in);
         k++;
      end
      chk("rise count", rises, base + n);
   endtask
   // Pin must hold one level for n clocks
   task automatic hold(input logic lv, input int n);
      int bad;
      bad = 0;
      repeat (n) begin
         @(posedge mclk_in);
         bad += (pin !== lv);
      end
      chk("pin level", bad, 0);
   endtask
   // Setup in order: driver off, period, mode, duty, flag clear, start, wait flag, driver on
   task automatic setup(input logic [1:0] ps, input logic [7:0] prd, dh, dl, input logic al);
      logic [31:0] ctl;
      int k;
      ctl = {26'h0, 1'b1, 1'b0, al, ps, 1'b0};
      k = 0;
      do_reset();
      bus(1'b1, `OFS_PERIOD, {24'h0, prd}, 4'hF);
      bus(1'b1, `OFS_CONTROL, ctl, 4'hF);
      bus(1'b1, `OFS_DUTY_HIGH, {24'h0, dh}, 4'hF);
      bus(1'b1, `OFS_DUTY_LOW, {24'h0, dl}, 4'hF);
      bus(1'b0, `OFS_STATUS, 32'h0, 4'hF);
      bus(1'b1, `OFS_CONTROL, ctl | 32'h1, 4'hF);
      do begin
         bus(1'b0, `OFS_STATUS, 32'h0, 4'hF);
         k++;
      end while (got[0] !== 1'b1 && k < 200);
      chk("period flag", got[0], 32'h1);
      chk("masked irq", irq, 32'h0);
      bus(1'b1, `OFS_CONTROL, ctl | 32'h11, 4'hF);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ------
   // Clock, watchdog and main sequence
   // ------
   initial begin
      mclk_in = 1'b0;
      forever #20 mclk_in = ~mclk_in;
   end
   initial begin
      #(40 * 30000);
      err_count++;
      $display("wrong value watchdog expected finish seen hang");
      complete_run();
   end
   initial begin
      rstn_in = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      adr = 5'h0;
      wdat = 32'h0;
      be = 4'h0;
      err_count = 0;
      tests_run = 0;
      do_reset();
      chk("pins after reset", {29'h0, pwm, oe, irq}, 32'h0);
      for (int i = 0; i < 5; i++) begin
         bus(1'b0, rv_adr[i], 32'h0, 4'hF);
         chk("reset value", got, rv_exp[i]);
      end
      $display("test reset done");
      foreach (rows[i]) begin
         setup(rows[i].ps, rows[i].prd, rows[i].dh, rows[i].dl, rows[i].al);
         wait_rise(3);
         chk("period clocks", per, rows[i].eper);
         chk("high clocks", high, rows[i].ehigh);
         $display("test row %0d done", i);
      end
      setup(2'h0, 8'h03, 8'h00, 8'h04, 1'b0);
      wait_rise(1);
      bus(1'b1, `OFS_DUTY_LOW, 32'h8, 4'hF);
      wait_rise(1);
      chk("old duty high", high, 32'h4);
      wait_rise(1);
      chk("new duty high", high, 32'h8);
      $display("test double buffer done");
      bus(1'b1, `OFS_PERIOD, 32'h0, 4'hE);
      bus(1'b0, `OFS_PERIOD, 32'h0, 4'hF);
      chk("period kept", got, 32'h3);
      bus(1'b0, 5'h1C, 32'h0, 4'hF);
      chk("unmapped read", got, 32'h0);
      $display("test refused access done");
      bus(1'b1, `OFS_DUTY_LOW, 32'h0, 4'hF);
      repeat (20) @(posedge mclk_in);
      hold(1'b0, 32);
      bus(1'b1, `OFS_DUTY_LOW, 32'hFF, 4'hF);
      repeat (20) @(posedge mclk_in);
      hold(1'b1, 32);
      $display("test duty limits done");
      bus(1'b1, `OFS_MASK, 32'h1, 4'hF);
      repeat (3) @(posedge mclk_in);
      chk("irq raised", irq, 32'h1);
      bus(1'b1, `OFS_MASK, 32'h0, 4'hF);
      repeat (3) @(posedge mclk_in);
      chk("irq masked", irq, 32'h0);
      bus(1'b1, `OFS_CONTROL, 32'h30, 4'hF);
      bus(1'b0, `OFS_STATUS, 32'h0, 4'hF);
      bus(1'b1, `OFS_MASK, 32'h1, 4'hF);
      repeat (3) @(posedge mclk_in);
      chk("irq cleared", irq, 32'h0);
      bus(1'b0, `OFS_STATUS, 32'h0, 4'hF);
      chk("flag cleared", got[0], 32'h0);
      chk("live level high", got[1], 32'h1);
      $display("test interrupt done");
      bus(1'b1, `OFS_CONTROL, 32'h10, 4'hF);
      repeat (2) @(posedge mclk_in);
      chk("pin disabled", pin, 32'h0);
      bus(1'b0, `OFS_STATUS, 32'h0, 4'hF);
      chk("live level low", got[1], 32'h0);
      $display("test disable done");
      complete_run();
   end
endmodule
`default_nettype wire
